// ==== wcl_top.sv ====
// Purpose: Warning detection, warning output and two event histories.
// Assumes: Inputs synchronous to MCLK; command frames arrive decoded.
// Notes: Histories are volatile and emptied by RSTN.
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module wcl_top (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic [wcl_pkg::MEAS_W-1:0] TEMP,
  input wire logic [wcl_pkg::MEAS_W-1:0] VMAIN,
  input wire logic [wcl_pkg::MEAS_W-1:0] TORQUE,
  input wire logic FORWARD_RUN_INPUT,
  input wire logic REVERSE_RUN_INPUT,
  input wire logic START_STOP_INPUT,
  input wire logic INPUT_A,
  input wire logic TEST_MODE,
  input wire logic ASSIGN_CHANGE,
  input wire logic ASSIGN_ACTIVE,
  input wire logic RX_FRAMING_ERR,
  input wire logic RX_CHECK_ERR,
  input wire logic RX_FRAME_OK,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_CODE,
  input wire logic [15:0] CMD_ARG,
  input wire logic UI_BUSY,
  input wire logic INTERNAL_BUSY_FLAG,
  input wire logic MEM_ALARM,
  input wire logic MOTOR_RUN,
  output logic WARNING_OUTPUT,
  output logic RSP_VALID,
  output logic [15:0] RSP_DATA,
  output logic [7:0] RSP_ERR
);
  import wcl_pkg::*;

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [11:0] temp_th;
  logic [6:0] uv_pct;
  logic [11:0] vrated;
  logic [11:0] ovl_th;
  logic three_wire;
  logic [4:0] hist_sel;
  logic wr_ctrl;
  logic [7:0] cmd_err;
  logic cmd_ok;

  assign wr_ctrl = WR && ADDR == REG_CTRL;
  assign cmd_ok = CMD_VALID && cmd_err == E_NONE;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      temp_th <= TEMP_TH_RST;
    end else if (WR && ADDR == REG_TEMP_TH) begin
      temp_th <= WDATA[11:0];
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      uv_pct <= UV_PCT_RST;
    end else if (cmd_ok && CMD_CODE == CMD_SET_UV) begin
      uv_pct <= CMD_ARG[6:0];
    end else if (WR && ADDR == REG_UV_PCT) begin
      uv_pct <= WDATA[6:0];
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      vrated <= VRATED_RST;
    end else if (WR && ADDR == REG_VRATED) begin
      vrated <= WDATA[11:0];
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ovl_th <= OVL_TH_RST;
    end else if (cmd_ok && CMD_CODE == CMD_SET_OVL) begin
      ovl_th <= CMD_ARG[11:0];
    end else if (WR && ADDR == REG_OVL_TH) begin
      ovl_th <= WDATA[11:0];
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      three_wire <= 1'b0;
      hist_sel <= '0;
    end else begin
      if (wr_ctrl) begin
        three_wire <= WDATA[CTRL_THREE_WIRE];
      end
      if (WR && ADDR == REG_HIST_SEL) begin
        hist_sel <= WDATA[4:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Warning causes
  // ----------------------------------------------------------------------
  logic [NCAUSE-1:0] cause;
  logic [NCAUSE-1:0] cause_q;
  logic [NCAUSE-1:0] pend;
  logic [NCAUSE-1:0] grant;
  logic [19:0] v_scaled;
  logic [19:0] v_limit;
  logic test_q;
  logic prohib;
  logic rx_warn;
  logic run_in;
  logic three_on;
  logic rx_fault;

  assign run_in = FORWARD_RUN_INPUT || REVERSE_RUN_INPUT;
  assign three_on = three_wire && START_STOP_INPUT && INPUT_A;
  assign rx_fault = RX_FRAMING_ERR || RX_CHECK_ERR;
  // Comparing scaled values avoids a divider for the percentage drop.
  assign v_scaled = 20'(VMAIN) * 20'd100;
  assign v_limit = 20'(vrated) * (20'd100 - 20'(uv_pct));

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      test_q <= 1'b0;
    end else begin
      test_q <= TEST_MODE;
    end
  end

  // The prohibition holds until every offending input has been released.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      prohib <= 1'b0;
    end else if (test_q && !TEST_MODE && run_in) begin
      prohib <= 1'b1;
    end else if (three_on) begin
      prohib <= 1'b1;
    end else if (ASSIGN_CHANGE && ASSIGN_ACTIVE) begin
      prohib <= 1'b1;
    end else if (!run_in && !three_on && !ASSIGN_ACTIVE) begin
      prohib <= 1'b0;
    end
  end

  // A reception fault stays a warning until a good frame arrives.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_warn <= 1'b0;
    end else if (rx_fault) begin
      rx_warn <= 1'b1;
    end else if (RX_FRAME_OK) begin
      rx_warn <= 1'b0;
    end
  end

  always_comb begin
    cause[0] = TEMP > temp_th;
    cause[1] = v_scaled <= v_limit;
    cause[2] = TORQUE > ovl_th;
    cause[3] = prohib;
    cause[4] = rx_warn;
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      WARNING_OUTPUT <= 1'b0;
    end else begin
      WARNING_OUTPUT <= |cause;
    end
  end

  // ----------------------------------------------------------------------
  // Warning logging
  // ----------------------------------------------------------------------
  // New warnings queue as pending bits, one logged per cycle, lowest first.
  always_comb begin
    grant = '0;
    for (int i = NCAUSE - 1; i >= 0; i--) begin
      if (pend[i]) begin
        grant = '0;
        grant[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      cause_q <= '0;
      pend <= '0;
    end else begin
      cause_q <= cause;
      pend <= (pend & ~grant) | (cause & ~cause_q);
    end
  end

  logic [7:0] next_wcode;
  always_comb begin
    next_wcode = '0;
    for (int i = 0; i < NCAUSE; i++) begin
      if (grant[i]) begin
        next_wcode = wcl_wcode(i);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Histories
  // ----------------------------------------------------------------------
  wcl_hist_if whist ();
  wcl_hist_if chist ();

  wcl_hist #(.DEPTH(HIST_DEPTH)) u_warn_hist (
    .clk(MCLK),
    .rst_n(RSTN),
    .h(whist)
  );

  wcl_hist #(.DEPTH(HIST_DEPTH)) u_comm_hist (
    .clk(MCLK),
    .rst_n(RSTN),
    .h(chist)
  );

  logic comm_pend;
  logic cmd_fail;

  assign cmd_fail = CMD_VALID && cmd_err != E_NONE;

  assign whist.push = |grant;
  assign whist.code = next_wcode;
  assign whist.clr = (wr_ctrl && WDATA[CTRL_CLR_WARN]) ||
                     (cmd_ok && CMD_CODE == CMD_CLR_WARN);
  assign whist.idx_a = hist_sel[3:0];
  assign whist.idx_b = CMD_ARG[3:0];

  // A refused command logs first; a framing fault waits one slot.
  assign chist.push = cmd_fail || comm_pend;
  assign chist.code = cmd_fail ? cmd_err : E_RS485;
  assign chist.clr = (wr_ctrl && WDATA[CTRL_CLR_COMM]) ||
                     (cmd_ok && CMD_CODE == CMD_CLR_COMM);
  assign chist.idx_a = hist_sel[3:0];
  assign chist.idx_b = CMD_ARG[3:0];

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      comm_pend <= 1'b0;
    end else begin
      comm_pend <= (comm_pend && cmd_fail) || rx_fault;
    end
  end

  // ----------------------------------------------------------------------
  // Master command check and response
  // ----------------------------------------------------------------------
  wcl_cmd_check u_check (
    .code(CMD_CODE),
    .arg(CMD_ARG),
    .ui_busy(UI_BUSY),
    .int_busy(INTERNAL_BUSY_FLAG),
    .mem_alarm(MEM_ALARM),
    .motor_run(MOTOR_RUN),
    .err(cmd_err)
  );

  logic [15:0] next_rsp;
  always_comb begin
    next_rsp = '0;
    if (CMD_CODE == CMD_MON_WARN) begin
      next_rsp = {8'h00, whist.data_b};
    end else if (CMD_CODE == CMD_MON_COMM) begin
      next_rsp = {8'h00, chist.data_b};
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      RSP_VALID <= 1'b0;
      RSP_DATA <= '0;
      RSP_ERR <= E_NONE;
    end else begin
      RSP_VALID <= CMD_VALID;
      RSP_DATA <= cmd_ok ? next_rsp : '0;
      RSP_ERR <= CMD_VALID ? cmd_err : E_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    unique case (ADDR)
      REG_CTRL: next_rdata[CTRL_THREE_WIRE] = three_wire;
      REG_TEMP_TH: next_rdata = {4'h0, temp_th};
      REG_UV_PCT: next_rdata = {9'h000, uv_pct};
      REG_VRATED: next_rdata = {4'h0, vrated};
      REG_OVL_TH: next_rdata = {4'h0, ovl_th};
      REG_STATUS: next_rdata = {10'h000, WARNING_OUTPUT, cause};
      REG_COUNT: next_rdata = {8'h00, chist.count, whist.count};
      REG_HIST_SEL: next_rdata = {11'h000, hist_sel};
      REG_HIST_DATA: begin
        next_rdata = {8'h00, hist_sel[SEL_COMM] ? chist.data_a
                                                : whist.data_a};
      end
      default: next_rdata = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= '0;
    end else begin
      RDATA <= RD ? next_rdata : '0;
    end
  end
endmodule
`default_nettype wire

// ==== wcl_pkg.sv ====
// Purpose: Shared constants for the warning and communication error logger.
// Assumes: One 50 MHz clock; histories live in flip-flops.
// Notes: Register offsets index a 16-bit plain register port.
`default_nettype none
package wcl_pkg;
  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int CODE_W = 8;
  localparam int IDX_W = 4;
  localparam int HIST_DEPTH = 10;
  localparam int MEAS_W = 12;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TEMP_TH = 4'h1;
  localparam logic [3:0] REG_UV_PCT = 4'h2;
  localparam logic [3:0] REG_VRATED = 4'h3;
  localparam logic [3:0] REG_OVL_TH = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_COUNT = 4'h6;
  localparam logic [3:0] REG_HIST_SEL = 4'h7;
  localparam logic [3:0] REG_HIST_DATA = 4'h8;
  // ----------------------------------------------------------------------
  // Field positions, reset values and range limits
  // ----------------------------------------------------------------------
  localparam int CTRL_CLR_WARN = 0;
  localparam int CTRL_CLR_COMM = 1;
  localparam int CTRL_THREE_WIRE = 2;
  localparam int SEL_COMM = 4;
  localparam logic [11:0] TEMP_TH_RST = 12'hC00;
  localparam logic [6:0] UV_PCT_RST = 7'h0A;
  localparam logic [6:0] UV_PCT_MIN = 7'h01;
  localparam logic [6:0] UV_PCT_MAX = 7'h32;
  localparam logic [11:0] VRATED_RST = 12'h800;
  localparam logic [11:0] OVL_TH_RST = 12'hA00;
  localparam logic [11:0] OVL_TH_MAX = 12'hFA0;
  // ----------------------------------------------------------------------
  // Warning and communication error codes
  // ----------------------------------------------------------------------
  localparam int NCAUSE = 5;
  localparam logic [7:0] W_OVERHEAT = 8'h21;
  localparam logic [7:0] W_UNDERVOLT = 8'h25;
  localparam logic [7:0] W_OVERLOAD = 8'h30;
  localparam logic [7:0] W_OP_PROHIB = 8'h6C;
  localparam logic [7:0] W_RS485 = 8'h84;
  localparam logic [7:0] E_RS485 = 8'h84;
  localparam logic [7:0] E_UNDEF = 8'h88;
  localparam logic [7:0] E_UI_BUSY = 8'h89;
  localparam logic [7:0] E_NVM_BUSY = 8'h8A;
  localparam logic [7:0] E_RANGE = 8'h8C;
  localparam logic [7:0] E_STATE = 8'h8D;
  localparam logic [7:0] E_NONE = 8'h00;
  // ----------------------------------------------------------------------
  // Master command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_MON_WARN = 8'h01;
  localparam logic [7:0] CMD_MON_COMM = 8'h02;
  localparam logic [7:0] CMD_CLR_WARN = 8'h11;
  localparam logic [7:0] CMD_CLR_COMM = 8'h12;
  localparam logic [7:0] CMD_SET_UV = 8'h21;
  localparam logic [7:0] CMD_SET_OVL = 8'h22;

  function automatic logic [7:0] wcl_wcode(input int i);
    logic [7:0] c;
    c = W_OVERHEAT;
    case (i)
      1: c = W_UNDERVOLT;
      2: c = W_OVERLOAD;
      3: c = W_OP_PROHIB;
      4: c = W_RS485;
      default: c = W_OVERHEAT;
    endcase
    return c;
  endfunction
endpackage
`default_nettype wire

// ==== wcl_hist_if.sv ====
// Purpose: Carrier between the logger core and one history store.
// Assumes: Two independent combinational read ports.
// Notes: Clear and push may coincide; the push survives.
`timescale 1ns/1ps
`default_nettype none
interface wcl_hist_if;
  import wcl_pkg::*;
  logic push;
  logic [CODE_W-1:0] code;
  logic clr;
  logic [IDX_W-1:0] idx_a;
  logic [IDX_W-1:0] idx_b;
  logic [CODE_W-1:0] data_a;
  logic [CODE_W-1:0] data_b;
  logic [IDX_W-1:0] count;
  modport store (input push, code, clr, idx_a, idx_b,
                 output data_a, data_b, count);
  modport user (output push, code, clr, idx_a, idx_b,
                input data_a, data_b, count);
endinterface
`default_nettype wire

// ==== wcl_hist.sv ====
// Purpose: Newest-first event history with a fixed number of entries.
// Assumes: DEPTH fits the index width.
// Notes: Contents vanish on reset, as on power removal.
`timescale 1ns/1ps
`default_nettype none
module wcl_hist #(
  parameter int DEPTH = wcl_pkg::HIST_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  wcl_hist_if.store h
);
  import wcl_pkg::*;
  localparam logic [IDX_W-1:0] FULL = IDX_W'(DEPTH);
  logic [CODE_W-1:0] mem [DEPTH];
  logic [IDX_W-1:0] count;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (h.push) begin
      // Shifting drops the oldest entry once the history is full.
      for (int i = DEPTH - 1; i > 0; i--) begin
        mem[i] <= mem[i-1];
      end
      mem[0] <= h.code;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (h.clr) begin
      count <= h.push ? IDX_W'(1) : '0;
    end else if (h.push && count != FULL) begin
      count <= count + IDX_W'(1);
    end
  end

  assign h.count = count;
  assign h.data_a = (h.idx_a < count) ? mem[h.idx_a] : '0;
  assign h.data_b = (h.idx_b < count) ? mem[h.idx_b] : '0;
endmodule
`default_nettype wire

// ==== wcl_cmd_check.sv ====
// Purpose: Classifies a master command into accept or an error code.
// Assumes: Purely combinational; caller registers the verdict.
// Notes: Earlier checks take precedence over later ones.
`timescale 1ns/1ps
`default_nettype none
module wcl_cmd_check (
  input wire logic [7:0] code,
  input wire logic [15:0] arg,
  input wire logic ui_busy,
  input wire logic int_busy,
  input wire logic mem_alarm,
  input wire logic motor_run,
  output logic [7:0] err
);
  import wcl_pkg::*;
  logic known;
  logic is_mon;
  logic is_set;
  logic bad_range;

  always_comb begin
    is_mon = code == CMD_MON_WARN || code == CMD_MON_COMM;
    is_set = code == CMD_SET_UV || code == CMD_SET_OVL;
    known = is_mon || is_set || code == CMD_CLR_WARN ||
            code == CMD_CLR_COMM;
    bad_range = 1'b0;
    if (is_mon) begin
      bad_range = arg >= 16'(HIST_DEPTH);
    end else if (code == CMD_SET_UV) begin
      bad_range = arg < 16'(UV_PCT_MIN) || arg > 16'(UV_PCT_MAX);
    end else if (code == CMD_SET_OVL) begin
      bad_range = arg > 16'(OVL_TH_MAX);
    end
    err = E_NONE;
    if (!known) begin
      err = E_UNDEF;
    end else if (ui_busy) begin
      err = E_UI_BUSY;
    end else if (int_busy || mem_alarm) begin
      err = E_NVM_BUSY;
    end else if (is_set && motor_run) begin
      err = E_STATE;
    end else if (bad_range) begin
      err = E_RANGE;
    end
  end
endmodule
`default_nettype wire

// ==== wcl_chk_sva.sv ====
// Purpose: Port-level checks of the logger's command and warning timing.
// Assumes: Sees only top module ports; one clock domain.
// Notes: Thresholds live in registers, so level checks stay in the bench.
`timescale 1ns/1ps
`default_nettype none
module wcl_chk (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_CODE,
  input wire logic UI_BUSY,
  input wire logic INTERNAL_BUSY_FLAG,
  input wire logic MEM_ALARM,
  input wire logic MOTOR_RUN,
  input wire logic ASSIGN_CHANGE,
  input wire logic ASSIGN_ACTIVE,
  input wire logic RX_FRAMING_ERR,
  input wire logic RX_CHECK_ERR,
  input wire logic WARNING_OUTPUT,
  input wire logic RSP_VALID,
  input wire logic [15:0] RSP_DATA,
  input wire logic [7:0] RSP_ERR
);
  import wcl_pkg::*;
  logic is_set;
  logic is_def;
  logic idle;
  assign is_set = CMD_CODE == CMD_SET_UV || CMD_CODE == CMD_SET_OVL;
  assign is_def = is_set || CMD_CODE == CMD_MON_WARN ||
    CMD_CODE == CMD_MON_COMM || CMD_CODE == CMD_CLR_WARN ||
    CMD_CODE == CMD_CLR_COMM;
  assign idle = !UI_BUSY && !INTERNAL_BUSY_FLAG && !MEM_ALARM;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);
  property p_rsp;
    CMD_VALID |=> RSP_VALID;
  endproperty
  a_rsp: assert property (p_rsp)
    else $error("no response one cycle after a command");
  property p_undef;
    CMD_VALID && !is_def |=> RSP_ERR == E_UNDEF;
  endproperty
  a_undef: assert property (p_undef)
    else $error("undefined command not refused");
  property p_ui;
    CMD_VALID && is_def && UI_BUSY |=> RSP_ERR == E_UI_BUSY;
  endproperty
  a_ui: assert property (p_ui)
    else $error("command not refused during user port traffic");
  property p_nvm;
    CMD_VALID && is_def && !UI_BUSY && (INTERNAL_BUSY_FLAG || MEM_ALARM)
      |=> RSP_ERR == E_NVM_BUSY;
  endproperty
  a_nvm: assert property (p_nvm)
    else $error("command not refused while memory busy");
  property p_state;
    CMD_VALID && is_set && idle && MOTOR_RUN |=> RSP_ERR == E_STATE;
  endproperty
  a_state: assert property (p_state)
    else $error("setting not refused while motor runs");
  property p_refdata;
    RSP_VALID && RSP_ERR != E_NONE |-> RSP_DATA == 16'h0000;
  endproperty
  a_refdata: assert property (p_refdata)
    else $error("refused command returned data");
  property p_rx;
    RX_FRAMING_ERR || RX_CHECK_ERR |-> ##[1:2] WARNING_OUTPUT;
  endproperty
  a_rx: assert property (p_rx)
    else $error("reception fault gave no warning");
  property p_assign;
    ASSIGN_CHANGE && ASSIGN_ACTIVE |-> ##[1:2] WARNING_OUTPUT;
  endproperty
  a_assign: assert property (p_assign)
    else $error("active terminal reassignment gave no warning");
endmodule
`default_nettype wire

// ==== wcl_master.sv ====
// Purpose: Master controller issuing decoded commands to the logger.
// Assumes: One command at a time, answer one cycle after it is taken.
// Notes: Released code and argument show inverted values, not stale ones.
`timescale 1ns/1ps
`default_nettype none
module wcl_master (
  input wire logic MCLK,
  output logic CMD_VALID,
  output logic [7:0] CMD_CODE,
  output logic [15:0] CMD_ARG,
  input wire logic RSP_VALID,
  input wire logic [15:0] RSP_DATA,
  input wire logic [7:0] RSP_ERR
);
  initial begin
    CMD_VALID = 1'b0;
    CMD_CODE = 8'h00;
    CMD_ARG = 16'h0000;
  end
  // Monitor and maintenance requests share this one path.
  task automatic cmd(input logic [7:0] c, input logic [15:0] a,
                     output logic [15:0] d, output logic [7:0] e);
    int n;
    n = 0;
    @(posedge MCLK);
    CMD_VALID <= 1'b1;
    CMD_CODE <= c;
    CMD_ARG <= a;
    @(posedge MCLK);
    CMD_VALID <= 1'b0;
    CMD_CODE <= ~c;
    CMD_ARG <= ~a;
    #1;
    while (RSP_VALID !== 1'b1 && n < 4) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    d = RSP_DATA;
    e = RSP_ERR;
  endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// Purpose: Self-checking bench for the warning and error logger.
// Assumes: Register port and master model speak the hand-over timing.
// Notes: Off levels of the temperature and torque causes sit exactly on the threshold.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wcl_pkg::*;
  logic MCLK = 1'b0;
  logic RSTN = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0, RD = 1'b0;
  logic [15:0] RDATA, RSP_DATA;
  logic [11:0] TEMP = 12'h000, VMAIN = 12'h800, TORQUE = 12'h000;
  logic FORWARD_RUN_INPUT = 1'b0, REVERSE_RUN_INPUT = 1'b0;
  logic START_STOP_INPUT = 1'b0, INPUT_A = 1'b0, TEST_MODE = 1'b0;
  logic ASSIGN_CHANGE = 1'b0, ASSIGN_ACTIVE = 1'b0;
  logic RX_FRAMING_ERR = 1'b0, RX_CHECK_ERR = 1'b0, RX_FRAME_OK = 1'b0;
  logic UI_BUSY = 1'b0, INTERNAL_BUSY_FLAG = 1'b0;
  logic MEM_ALARM = 1'b0, MOTOR_RUN = 1'b0;
  logic CMD_VALID, WARNING_OUTPUT, RSP_VALID;
  logic [7:0] CMD_CODE, RSP_ERR;
  logic [15:0] CMD_ARG;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] wc [5] = '{8'h21, 8'h25, 8'h30, 8'h6C, 8'h84};
  logic [7:0] tc [9] = '{8'h55, CMD_MON_WARN, CMD_MON_WARN, CMD_MON_WARN,
    CMD_SET_UV, CMD_SET_UV, CMD_SET_OVL, CMD_SET_UV, CMD_MON_COMM};
  logic [15:0] ta [9] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h33,
    16'hFA1, 16'h14, 16'hA};
  logic [3:0] tl [9] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h0, 4'h0, 4'h0, 4'h1,
    4'h0};
  logic [7:0] te [9] = '{8'h88, 8'h89, 8'h8A, 8'h8A, 8'h8C, 8'h8C, 8'h8C,
    8'h8D, 8'h8C};
  always #10 MCLK = ~MCLK;
  wcl_top i_dut (.*);
  wcl_master i_mst (.*);
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // The ceiling is more than forty times the length of the full sequence.
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      final_report;
    end
  end
  task automatic chk(input string nm, input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [3:0] a,
                    input logic [15:0] e);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 chk(nm, RDATA, e);
  endtask
  task automatic hc(input logic [15:0] sel, input logic [7:0] e);
    wr(REG_HIST_SEL, sel);
    rc("entry", REG_HIST_DATA, {8'h00, e});
  endtask
  task automatic mc(input logic [7:0] c, input logic [15:0] a,
                    input logic [7:0] ed, input logic [7:0] ee);
    logic [15:0] d;
    logic [7:0] e;
    i_mst.cmd(c, a, d, e);
    chk("rsp err", {8'h00, e}, {8'h00, ee});
    if (c < 8'h10) chk("rsp data", d, {8'h00, ed});
  endtask
  task automatic cause(input int k, input logic on);
    @(posedge MCLK);
    case (k)
      0: TEMP <= on ? 12'hC01 : 12'hC00;
      1: VMAIN <= on ? 12'h733 : 12'h734;
      2: TORQUE <= on ? 12'hA01 : 12'hA00;
      3: begin
        ASSIGN_ACTIVE <= on;
        ASSIGN_CHANGE <= on;
      end
      default: begin
        RX_FRAMING_ERR <= on;
        RX_FRAME_OK <= !on;
      end
    endcase
    @(posedge MCLK);
    ASSIGN_CHANGE <= 1'b0;
    RX_FRAMING_ERR <= 1'b0;
    RX_FRAME_OK <= 1'b0;
    repeat (4) @(posedge MCLK);
  endtask
  initial begin
    repeat (4) @(posedge MCLK);
    RSTN <= 1'b1;
    rc("status", REG_STATUS, 16'h0000);
    rc("count", REG_COUNT, 16'h0000);
    rc("temp th", REG_TEMP_TH, 16'h0C00);
    rc("uv pct", REG_UV_PCT, 16'h000A);
    rc("vrated", REG_VRATED, 16'h0800);
    rc("ovl th", REG_OVL_TH, 16'h0A00);
    rc("unmapped", 4'hF, 16'h0000);
    $display("test reset values done");
    for (int k = 0; k < NCAUSE; k++) begin
      cause(k, 1'b0);
      rc("idle", REG_STATUS, 16'h0000);
      cause(k, 1'b1);
      rc("on", REG_STATUS, 16'h0020 | (16'h0001 << k));
      chk("warning", 16'(WARNING_OUTPUT), 16'h0001);
      cause(k, 1'b0);
      rc("off", REG_STATUS, 16'h0000);
    end
    rc("count", REG_COUNT, 16'h0015);
    for (int i = 0; i < 5; i++) hc(16'(i), wc[4 - i]);
    hc(16'h0010, E_RS485);
    mc(CMD_MON_WARN, 16'h0, W_RS485, E_NONE);
    mc(CMD_MON_COMM, 16'h0, E_RS485, E_NONE);
    $display("test warning causes done");
    TEST_MODE <= 1'b1;
    FORWARD_RUN_INPUT <= 1'b1;
    repeat (3) @(posedge MCLK);
    TEST_MODE <= 1'b0;
    repeat (4) @(posedge MCLK);
    rc("test exit", REG_STATUS, 16'h0028);
    FORWARD_RUN_INPUT <= 1'b0;
    wr(REG_CTRL, 16'h0004);
    START_STOP_INPUT <= 1'b1;
    INPUT_A <= 1'b1;
    repeat (4) @(posedge MCLK);
    rc("three wire", REG_STATUS, 16'h0028);
    rc("ctrl", REG_CTRL, 16'h0004);
    START_STOP_INPUT <= 1'b0;
    INPUT_A <= 1'b0;
    wr(REG_CTRL, 16'h0000);
    for (int i = 0; i < 11; i++) begin
      cause(3, 1'b1);
      cause(3, 1'b0);
    end
    cause(0, 1'b1);
    rc("full", REG_COUNT, 16'h001A);
    hc(16'h0, W_OVERHEAT);
    hc(16'h9, W_OP_PROHIB);
    hc(16'hA, E_NONE);
    cause(0, 1'b0);
    mc(CMD_CLR_WARN, 16'h0, E_NONE, E_NONE);
    rc("cleared", REG_COUNT, 16'h0010);
    $display("test history done");
    wr(REG_CTRL, 16'h0002);
    rc("comm clr", REG_COUNT, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      @(posedge MCLK);
      {UI_BUSY, INTERNAL_BUSY_FLAG, MEM_ALARM, MOTOR_RUN} <= tl[i];
      mc(tc[i], ta[i], E_NONE, te[i]);
      {UI_BUSY, INTERNAL_BUSY_FLAG, MEM_ALARM, MOTOR_RUN} <= 4'h0;
    end
    rc("comm count", REG_COUNT, 16'h0090);
    for (int i = 0; i < 9; i++) mc(CMD_MON_COMM, 16'(i), te[8 - i], E_NONE);
    mc(CMD_SET_UV, 16'h0014, E_NONE, E_NONE);
    rc("uv set", REG_UV_PCT, 16'h0014);
    mc(CMD_SET_OVL, 16'h0FA0, E_NONE, E_NONE);
    rc("ovl set", REG_OVL_TH, 16'h0FA0);
    mc(CMD_CLR_COMM, 16'h0, E_NONE, E_NONE);
    rc("comm none", REG_COUNT, 16'h0000);
    $display("test command errors done");
    cause(4, 1'b1);
    cause(4, 1'b0);
    RSTN <= 1'b0;
    repeat (2) @(posedge MCLK);
    RSTN <= 1'b1;
    rc("power cycle", REG_COUNT, 16'h0000);
    $display("test power cycle done");
    final_report;
  end
endmodule
bind wcl_top wcl_chk i_chk (.*);
`default_nettype wire
